// >>> include/diag_flags_pkg.sv
// Constants, register map and types for the diagnostic alarm and warning flag block.
// Notes on behaviour
// [R1] Twenty strict high/low threshold comparisons, four per result.
// [R2] Alarms: temp,volt,bias,tx 7..0; rx 7,6.
// [R3] Warnings use same bit order in warning registers.
// [R4] A true condition sets its status bit.
// [R5] No host mask on status bit setting.
// [R6] Bits stay until read, power cycle, tx-disable toggle.
// [R7] Tx-disable asserted: results and events keep going.
// [R8] Tx-disable release clears all four status registers.
// [R9] Rx-loss, rate-select, tx-fault are open-drain outputs.
// [R10] Status bits report sampled pin levels.
// [R11] Warm reset deasserts tx-fault and rx-loss.
// [R12] Warm reset restores all registers to defaults.
// [R13] Warm reset discards conversion in progress.
// [R14] Continuity mode forces rx-loss, tx-fault, interrupt pins.
// [R15] Read-back register shows reset-output and interrupt pins.
// [R16] Host reads via two-wire byte read sequence.
// [R17] Compare each new result with its own thresholds.
// [R18] Event in the clearing cycle still sets bit.
package diag_flags_pkg;

  localparam logic [6:0] DEV_ADDR = 7'h51;
  localparam int NUM_CHAN = 5;
  localparam int THR_BYTES = 40;

  localparam logic [7:0] THR_BASE_OFFSET = 8'h00;
  localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h6e;
  localparam logic [7:0] ALARM_LOW_OFFSET = 8'h70;
  localparam logic [7:0] ALARM_HIGH_OFFSET = 8'h71;
  localparam logic [7:0] WARN_LOW_OFFSET = 8'h74;
  localparam logic [7:0] WARN_HIGH_OFFSET = 8'h75;
  localparam logic [7:0] OEM_CONFIG_OFFSET = 8'h90;
  localparam logic [7:0] OEM_CAL_OFFSET = 8'h91;
  localparam logic [7:0] OEM_READBACK_OFFSET = 8'h92;

  localparam int THR_HI_ALARM = 0;
  localparam int THR_LO_ALARM = 2;
  localparam int THR_HI_WARN = 4;
  localparam int THR_LO_WARN = 6;

  localparam int CTRL_TXDIS_BIT = 7;
  localparam int CTRL_RATE_LVL_BIT = 4;
  localparam int CTRL_RATE_SOFT_BIT = 3;
  localparam int CTRL_TXFAULT_BIT = 2;
  localparam int CTRL_RXLOS_BIT = 1;

  localparam int WARM_RESET_BIT = 7;
  localparam int CC_ENABLE_BIT = 7;
  localparam int CC_RXLOS_BIT = 2;
  localparam int CC_TXFAULT_BIT = 1;
  localparam int CC_INT_BIT = 0;
  localparam int RB_RESET_OUT_BIT = 1;
  localparam int RB_INT_BIT = 0;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [9:0] FLAGS_RESET = 10'h000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h2,
    ST_WR = 3'h3,
    ST_WACK = 3'h4,
    ST_RD = 3'h5,
    ST_RACK = 3'h6
  } serial_state_e;

endpackage

// >>> hw/diag_alarm_warning_flags.sv
// Alarm and warning flag bank with two-wire serial register access and pin control.
`timescale 1ns/1ps
module diag_alarm_warning_flags #(
  parameter int VALUE_W = 16
) (
  input wire logic clk, // 20 MHz clock
  input wire logic reset, // asynchronous, active high
  input wire logic scl, // serial clock pin level
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // serial data drive level, always low
  output logic sda_oe, // serial data pull-down enable
  input wire logic res_valid, // new conversion result strobe
  input wire logic [2:0] res_chan, // 0 temp, 1 volt, 2 bias, 3 tx power, 4 rx power
  input wire logic [VALUE_W-1:0] res_value, // conversion result
  input wire logic rx_los_int, // internal receive-loss request
  input wire logic tx_fault_int, // internal transmit-fault request
  input wire logic int_req, // internal interrupt request
  input wire logic rx_los_i, // receive-loss pin level
  input wire logic rate_sel_i, // rate-select pin level
  input wire logic tx_fault_i, // transmit-fault pin level
  input wire logic int_n_i, // interrupt pin level
  input wire logic reset_out_i, // reset-output pin level
  input wire logic tx_disable_i, // transmit-disable pin level
  output logic [3:0] od_o, // drive levels of open-drain pins, always low
  output logic rx_los_oe, // receive-loss pull-down enable
  output logic rate_sel_oe, // rate-select pull-down enable
  output logic tx_fault_oe, // transmit-fault pull-down enable
  output logic int_n_oe, // interrupt pull-down enable
  output logic warm_pulse // one-cycle warm reset and conversion abort
);

  // Pin order in the synchroniser vector.
  localparam int P_SCL = 0;
  localparam int P_SDA = 1;
  localparam int P_RXLOS = 2;
  localparam int P_RATE = 3;
  localparam int P_TXF = 4;
  localparam int P_INT = 5;
  localparam int P_RSTO = 6;
  localparam int P_TXDIS = 7;

  logic [7:0] pin_m_q, pin_s_q, pin_p_q, pin_raw;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  diag_flags_pkg::serial_state_e st_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic rw_q;
  logic first_q;
  logic [7:0] ptr_q;
  logic rd_take, wr_take, warm, warm_q;
  logic [7:0] thr_q [0:diag_flags_pkg::THR_BYTES-1];
  logic [9:0] alarm_q, warn_q, alarm_ev, warn_ev, rd_clr_a, rd_clr_w;
  logic txdis_release;
  logic rate_soft_q;
  logic [6:0] oem_cfg_q;
  logic [7:0] oem_cal_q;
  logic [7:0] rdata;
  logic cc_on;

  assign pin_raw = {tx_disable_i, reset_out_i, int_n_i, tx_fault_i,
                    rate_sel_i, rx_los_i, sda_i, scl};

  // Every pin passes two flops; edge detection only looks at the second stage onward.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_m_q <= 8'hff;
      pin_s_q <= 8'hff;
      pin_p_q <= 8'hff;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end

  assign scl_rise = pin_s_q[P_SCL] & ~pin_p_q[P_SCL];
  assign scl_fall = ~pin_s_q[P_SCL] & pin_p_q[P_SCL];
  assign bus_start = pin_s_q[P_SCL] & pin_p_q[P_SCL] & pin_p_q[P_SDA] & ~pin_s_q[P_SDA];
  assign bus_stop = pin_s_q[P_SCL] & pin_p_q[P_SCL] & ~pin_p_q[P_SDA] & pin_s_q[P_SDA];
  assign txdis_release = pin_p_q[P_TXDIS] & ~pin_s_q[P_TXDIS];

  function automatic logic [15:0] limit(input logic [2:0] chan, input int sel);
    int base;
    base = int'(chan) * 8 + sel;
    limit = {thr_q[base], thr_q[base + 1]};
  endfunction

  function automatic logic [9:0] place(input logic [2:0] chan, input logic hi, input logic lo);
    place = 10'({hi, lo}) << (4'd8 - {chan, 1'b0});
  endfunction

  // Register read mux.
  always_comb begin
    rdata = 8'h00;
    if (ptr_q < 8'(diag_flags_pkg::THR_BYTES)) begin
      rdata = thr_q[ptr_q[5:0]];
    end else begin
      case (ptr_q)
        diag_flags_pkg::ALARM_LOW_OFFSET: rdata = alarm_q[9:2];
        diag_flags_pkg::ALARM_HIGH_OFFSET: rdata = {alarm_q[1:0], 6'h00};
        diag_flags_pkg::WARN_LOW_OFFSET: rdata = warn_q[9:2];
        diag_flags_pkg::WARN_HIGH_OFFSET: rdata = {warn_q[1:0], 6'h00};
        diag_flags_pkg::CTRL_STATUS_OFFSET: begin
          rdata[diag_flags_pkg::CTRL_TXDIS_BIT] = pin_s_q[P_TXDIS];
          rdata[diag_flags_pkg::CTRL_RATE_LVL_BIT] = pin_s_q[P_RATE]; // R10
          rdata[diag_flags_pkg::CTRL_RATE_SOFT_BIT] = rate_soft_q;
          rdata[diag_flags_pkg::CTRL_TXFAULT_BIT] = pin_s_q[P_TXF]; // R10
          rdata[diag_flags_pkg::CTRL_RXLOS_BIT] = pin_s_q[P_RXLOS]; // R10
        end
        diag_flags_pkg::OEM_CONFIG_OFFSET: rdata = {1'b0, oem_cfg_q};
        diag_flags_pkg::OEM_CAL_OFFSET: rdata = oem_cal_q;
        diag_flags_pkg::OEM_READBACK_OFFSET: begin
          rdata[diag_flags_pkg::RB_RESET_OUT_BIT] = pin_s_q[P_RSTO]; // R15
          rdata[diag_flags_pkg::RB_INT_BIT] = pin_s_q[P_INT]; // R15
        end
        default: rdata = 8'h00;
      endcase
    end
  end

  // A byte is taken for reading when it is loaded into the shifter.
  assign rd_take = (st_q == diag_flags_pkg::ST_AACK) & scl_fall & rw_q; // R16
  assign wr_take = (st_q == diag_flags_pkg::ST_WR) & scl_fall & (cnt_q == 4'h8) & ~first_q;
  assign warm = wr_take & (ptr_q == diag_flags_pkg::OEM_CONFIG_OFFSET)
                & sh_q[diag_flags_pkg::WARM_RESET_BIT];

  // Serial slave. Its own progress is kept through a warm reset so the write is acknowledged.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= diag_flags_pkg::ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b1;
      ptr_q <= 8'h00;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      st_q <= diag_flags_pkg::ST_ADDR;
      cnt_q <= 4'h0;
      first_q <= 1'b1;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      st_q <= diag_flags_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (st_q)
        diag_flags_pkg::ST_ADDR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], pin_s_q[P_SDA]};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            if (sh_q[7:1] == diag_flags_pkg::DEV_ADDR) begin
              sda_oe <= 1'b1;
              rw_q <= sh_q[0];
              st_q <= diag_flags_pkg::ST_AACK;
            end else begin
              st_q <= diag_flags_pkg::ST_IDLE;
            end
          end
        end
        diag_flags_pkg::ST_AACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              sh_q <= rdata;
              sda_oe <= ~rdata[7];
              cnt_q <= 4'h1;
              ptr_q <= ptr_q + 8'h01;
              st_q <= diag_flags_pkg::ST_RD;
            end else begin
              sda_oe <= 1'b0;
              cnt_q <= 4'h0;
              st_q <= diag_flags_pkg::ST_WR;
            end
          end
        end
        diag_flags_pkg::ST_WR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], pin_s_q[P_SDA]};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            sda_oe <= 1'b1;
            first_q <= 1'b0;
            ptr_q <= first_q ? sh_q : ptr_q + 8'h01;
            st_q <= diag_flags_pkg::ST_WACK;
          end
        end
        diag_flags_pkg::ST_WACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= diag_flags_pkg::ST_WR;
          end
        end
        diag_flags_pkg::ST_RD: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              sda_oe <= 1'b0;
              st_q <= diag_flags_pkg::ST_RACK;
            end else begin
              sda_oe <= ~sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        diag_flags_pkg::ST_RACK: begin
          // A host acknowledge asks for the next byte; reuse the load path.
          if (scl_rise) begin
            st_q <= pin_s_q[P_SDA] ? diag_flags_pkg::ST_IDLE : diag_flags_pkg::ST_AACK;
          end
        end
        default: st_q <= diag_flags_pkg::ST_IDLE;
      endcase
    end
  end

  // Writable registers; a warm reset returns every one to its power-on value.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < diag_flags_pkg::THR_BYTES; i++) begin
        thr_q[i] <= diag_flags_pkg::REG_RESET;
      end
      rate_soft_q <= 1'b0;
      oem_cfg_q <= 7'h00;
      oem_cal_q <= diag_flags_pkg::REG_RESET;
    end else if (warm) begin
      for (int i = 0; i < diag_flags_pkg::THR_BYTES; i++) begin
        thr_q[i] <= diag_flags_pkg::REG_RESET; // R12
      end
      rate_soft_q <= 1'b0; // R12
      oem_cfg_q <= 7'h00; // R12
      oem_cal_q <= diag_flags_pkg::REG_RESET; // R12
    end else if (wr_take) begin
      if (ptr_q < 8'(diag_flags_pkg::THR_BYTES)) begin
        thr_q[ptr_q[5:0]] <= sh_q;
      end
      if (ptr_q == diag_flags_pkg::CTRL_STATUS_OFFSET) begin
        rate_soft_q <= sh_q[diag_flags_pkg::CTRL_RATE_SOFT_BIT];
      end
      if (ptr_q == diag_flags_pkg::OEM_CONFIG_OFFSET) begin
        oem_cfg_q <= sh_q[6:0];
      end
      if (ptr_q == diag_flags_pkg::OEM_CAL_OFFSET) begin
        oem_cal_q <= sh_q;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      warm_q <= 1'b0;
    end else begin
      warm_q <= warm;
    end
  end

  // Threshold checks. Results arriving during a warm reset belong to an aborted conversion.
  always_comb begin
    alarm_ev = 10'h000;
    warn_ev = 10'h000;
    if (res_valid && !warm && !warm_q && res_chan < 3'(diag_flags_pkg::NUM_CHAN)) begin // R13 R17
      alarm_ev = place(res_chan,
        res_value > limit(res_chan, diag_flags_pkg::THR_HI_ALARM), // R1 R2
        res_value < limit(res_chan, diag_flags_pkg::THR_LO_ALARM)); // R1 R2
      warn_ev = place(res_chan,
        res_value > limit(res_chan, diag_flags_pkg::THR_HI_WARN), // R1 R3
        res_value < limit(res_chan, diag_flags_pkg::THR_LO_WARN)); // R1 R3
    end
  end

  always_comb begin
    rd_clr_a = 10'h000;
    rd_clr_w = 10'h000;
    if (rd_take) begin
      case (ptr_q)
        diag_flags_pkg::ALARM_LOW_OFFSET: rd_clr_a = 10'h3fc; // R6
        diag_flags_pkg::ALARM_HIGH_OFFSET: rd_clr_a = 10'h003; // R6
        diag_flags_pkg::WARN_LOW_OFFSET: rd_clr_w = 10'h3fc; // R6
        diag_flags_pkg::WARN_HIGH_OFFSET: rd_clr_w = 10'h003; // R6
        default: rd_clr_a = 10'h000;
      endcase
    end
    if (txdis_release) begin
      rd_clr_a = 10'h3ff; // R8
      rd_clr_w = 10'h3ff; // R8
    end
  end

  // Sticky flags with no mask; a new event beats a read or tx-disable release clear in the same cycle, but not a warm reset.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alarm_q <= diag_flags_pkg::FLAGS_RESET;
      warn_q <= diag_flags_pkg::FLAGS_RESET;
    end else if (warm) begin
      alarm_q <= diag_flags_pkg::FLAGS_RESET; // R12
      warn_q <= diag_flags_pkg::FLAGS_RESET; // R12
    end else begin
      alarm_q <= (alarm_q & ~rd_clr_a) | alarm_ev; // R4 R5 R7 R18
      warn_q <= (warn_q & ~rd_clr_w) | warn_ev; // R4 R5 R7 R18
    end
  end

  assign cc_on = oem_cal_q[diag_flags_pkg::CC_ENABLE_BIT];

  // Open-drain drivers only ever pull low; an enable means the line is held low.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sda_o <= 1'b0;
      od_o <= 4'h0;
      rx_los_oe <= 1'b1;
      tx_fault_oe <= 1'b1;
      rate_sel_oe <= 1'b1;
      int_n_oe <= 1'b0;
      warm_pulse <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      od_o <= 4'h0; // R9
      warm_pulse <= warm; // R13
      rate_sel_oe <= ~rate_soft_q; // R9
      if (warm) begin
        rx_los_oe <= 1'b1; // R11
        tx_fault_oe <= 1'b1; // R11
        int_n_oe <= 1'b0;
      end else if (cc_on) begin
        rx_los_oe <= ~oem_cal_q[diag_flags_pkg::CC_RXLOS_BIT]; // R14
        tx_fault_oe <= ~oem_cal_q[diag_flags_pkg::CC_TXFAULT_BIT]; // R14
        int_n_oe <= oem_cal_q[diag_flags_pkg::CC_INT_BIT]; // R14
      end else begin
        rx_los_oe <= ~rx_los_int; // R9
        tx_fault_oe <= ~tx_fault_int; // R9
        int_n_oe <= int_req;
      end
    end
  end

endmodule

// >>> sim/diag_flags_chk.sv
// Concurrent checks on the pin and serial timing of the flag bank.
`timescale 1ns/1ps
module diag_flags_chk (
  input wire logic clk, // clock
  input wire logic reset, // asynchronous reset
  input wire logic scl, // serial clock pin
  input wire logic sda_o, // data drive level
  input wire logic sda_oe, // data pull-down enable
  input wire logic [3:0] od_o, // open-drain drive levels
  input wire logic rx_los_int, // receive-loss request
  input wire logic tx_fault_int, // transmit-fault request
  input wire logic int_req, // interrupt request
  input wire logic rx_los_oe, // receive-loss enable
  input wire logic tx_fault_oe, // transmit-fault enable
  input wire logic rate_sel_oe, // rate-select enable
  input wire logic int_n_oe, // interrupt enable
  input wire logic warm_pulse // warm reset pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // The sync chain puts every data change a few clocks behind the clock fall.
  sequence s_fall_seen;
    !$past(scl) && ($past(scl, 3) || $past(scl, 4) || $past(scl, 5) || $past(scl, 6));
  endsequence
  sequence s_warm_quiet;
    warm_pulse ##1 (!rx_los_int && !tx_fault_int && !int_req);
  endsequence
  property p_od_low; od_o == 4'h0 && sda_o == 1'b0; endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain level not low");
  property p_sda_scl_low; $changed(sda_oe) |-> !scl && !$past(scl); endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("data moved in clock high");
  property p_ack_rise; $rose(sda_oe) |-> s_fall_seen; endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("data pull not after fall");
  property p_ack_fall; $fell(sda_oe) |-> s_fall_seen; endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("data release not after fall");
  property p_warm_single; warm_pulse |=> !warm_pulse [*8]; endproperty
  a_warm_single: assert property (p_warm_single) else $error("warm pulse repeated");
  property p_warm_pins; s_warm_quiet |=> rx_los_oe && tx_fault_oe; endproperty
  a_warm_pins: assert property (p_warm_pins) else $error("fault pins not deasserted");
  property p_warm_int; s_warm_quiet |=> !int_n_oe; endproperty
  a_warm_int: assert property (p_warm_int) else $error("interrupt still forced");
  property p_warm_rate; warm_pulse |=> ##1 rate_sel_oe; endproperty
  a_warm_rate: assert property (p_warm_rate) else $error("rate control not reset");
endmodule

// >>> sim/i2c_host_model.sv
// Two-wire bus host that reads and writes the flag bank registers.
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic clk, // bench clock
  input wire logic sda, // resolved data line
  output logic scl, // serial clock, stands high between frames
  output logic sda_low // high while the host pulls data low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Four clocks per phase keeps the device's two-flop sampling comfortably inside each phase.
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hold(4);
    scl = 1'b1;
    hold(4);
    r = sda;
    hold(4);
    scl = 1'b0;
    hold(4);
  endtask
  task automatic start();
    sda_low = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_low = 1'b1;
    hold(4);
    scl = 1'b0;
    hold(4);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_low = 1'b0;
    hold(4);
  endtask
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ack);
    logic k0, k1, k2;
    start();
    byte_out({diag_flags_pkg::DEV_ADDR, 1'b0}, k0);
    byte_out(a, k1);
    byte_out(d, k2);
    stop();
    ack = k0 & k1 & k2;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    byte_out({diag_flags_pkg::DEV_ADDR, 1'b0}, k);
    byte_out(a, k);
    start();
    byte_out({diag_flags_pkg::DEV_ADDR, 1'b1}, k);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, k);
    stop();
  endtask
endmodule

// >>> sim/diag_alarm_warning_flags_tb_top.sv
// Self-checking bench for the alarm and warning flag bank.
`timescale 1ns/1ps
`define CHK(g, w) begin compares++; if ((g) !== (w)) begin miscompares++; \
  $display("Error %0t: got %h want %h", $time, g, w); end end
module diag_alarm_warning_flags_tb_top;
  logic clk, reset, res_valid, rx_los_int, tx_fault_int, int_req, reset_out_i, tx_disable_i;
  logic scl, host_low, sda_o, sda_oe, warm_pulse, ack;
  logic rx_los_oe, rate_sel_oe, tx_fault_oe, int_n_oe;
  logic [2:0] res_chan;
  logic [15:0] res_value;
  logic [3:0] ext, od_o;
  logic [7:0] d;
  logic [31:0] seed, r;
  int miscompares, compares, thr[20], mf[4], c, v;
  int base[4] = '{32'h0000_c000, 32'h0000_4000, 32'h0000_a000, 32'h0000_6000};
  logic [7:0] map[4] = '{8'h70, 8'h71, 8'h74, 8'h75};
  // Every shared line has a pull-up, so a released line reads high.
  wire logic sda = !(sda_oe | host_low);
  wire logic rx_los_i = !(rx_los_oe | ext[0]);
  wire logic rate_sel_i = !(rate_sel_oe | ext[1]);
  wire logic tx_fault_i = !(tx_fault_oe | ext[2]);
  wire logic int_n_i = !(int_n_oe | ext[3]);
  diag_alarm_warning_flags u_diag_alarm_warning_flags (.clk(clk), .reset(reset), .scl(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .res_valid(res_valid), .res_chan(res_chan),
    .res_value(res_value), .rx_los_int(rx_los_int), .tx_fault_int(tx_fault_int),
    .int_req(int_req), .rx_los_i(rx_los_i), .rate_sel_i(rate_sel_i), .tx_fault_i(tx_fault_i),
    .int_n_i(int_n_i), .reset_out_i(reset_out_i), .tx_disable_i(tx_disable_i), .od_o(od_o),
    .rx_los_oe(rx_los_oe), .rate_sel_oe(rate_sel_oe), .tx_fault_oe(tx_fault_oe),
    .int_n_oe(int_n_oe), .warm_pulse(warm_pulse));
  i2c_host_model u_i2c_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic put(input int c, input int v);
    int g, b;
    g = c / 4;
    b = (c < 4) ? 7 - 2 * c : 7;
    res_chan = 3'(c);
    res_value = 16'(v);
    res_valid = 1'b1;
    @(posedge clk);
    #2;
    res_valid = 1'b0;
    if (c < 5) begin
      if (v > thr[4 * c]) mf[g] |= 1 << b;
      if (v < thr[4 * c + 1]) mf[g] |= 1 << (b - 1);
      if (v > thr[4 * c + 2]) mf[g + 2] |= 1 << b;
      if (v < thr[4 * c + 3]) mf[g + 2] |= 1 << (b - 1);
    end
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] w);
    u_i2c_host_model.read_reg(a, d);
    `CHK(d & m, w & m)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    u_i2c_host_model.write_reg(a, x, ack);
    `CHK(ack, 1'b1)
  endtask
  task automatic check_flags();
    for (int i = 0; i < 4; i++) begin
      expect_reg(map[i], 8'hff, 8'(mf[i]));
      mf[i] = 0;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    {reset, res_valid, rx_los_int, tx_fault_int, int_req, reset_out_i, tx_disable_i} = 7'h40;
    {res_chan, res_value, ext, seed} = {19'h0_0000, 4'h0, 32'h0000_05dd};
    repeat (2) @(posedge clk);
    #2;
    reset = 1'b0;
    u_i2c_host_model.hold(4);
    check_flags();
    for (int i = 0; i < 20; i++) begin
      thr[i] = base[i % 4] + 256 * (i / 4);
      wr(8'(2 * i), 8'(thr[i] >> 8));
      wr(8'(2 * i + 1), 8'(thr[i]));
    end
    repeat (3) begin
      repeat (12) begin
        c = int'(xs() % 6);
        v = (c < 5) ? thr[4 * c + int'(xs() % 4)] + int'(xs() % 3) - 1 : 32'h0000_ffff;
        put(c, v);
      end
      check_flags();
    end
    tx_disable_i = 1'b1;
    put(0, thr[0] + 1);
    put(4, 0);
    expect_reg(8'h70, 8'hff, 8'(mf[0]));
    tx_disable_i = 1'b0;
    u_i2c_host_model.hold(6);
    mf = '{0, 0, 0, 0};
    check_flags();
    repeat (4) begin
      r = xs();
      ext = 4'(xs());
      {reset_out_i, tx_disable_i, int_req, tx_fault_int, rx_los_int} = r[4:0];
      u_i2c_host_model.hold(4);
      `CHK({rx_los_oe, tx_fault_oe, int_n_oe}, {!r[0], !r[1], r[2]})
      expect_reg(8'h6e, 8'h96, {r[3], 4'h0, r[1] & !ext[2], r[0] & !ext[0], 1'b0});
      expect_reg(8'h92, 8'h03, {6'h00, r[4], !(r[2] | ext[3])});
    end
    {ext, tx_disable_i, int_req, tx_fault_int, rx_los_int} = 8'h0f;
    wr(8'h91, 8'h80);
    `CHK({rx_los_oe, tx_fault_oe, int_n_oe}, 3'b110)
    {int_req, tx_fault_int, rx_los_int} = 3'b000;
    wr(8'h91, 8'h87);
    `CHK({rx_los_oe, tx_fault_oe, int_n_oe}, 3'b001)
    wr(8'h6e, 8'h08);
    expect_reg(8'h6e, 8'h18, 8'h18);
    put(0, 32'h0000_ffff);
    wr(diag_flags_pkg::OEM_CONFIG_OFFSET, 8'h80);
    u_i2c_host_model.hold(4);
    `CHK({rx_los_oe, tx_fault_oe, int_n_oe, rate_sel_oe}, 4'b1101)
    expect_reg(8'h91, 8'hff, 8'h00);
    expect_reg(8'h00, 8'hff, 8'h00);
    expect_reg(8'h6e, 8'h18, 8'h00);
    thr = '{default: 0};
    mf = '{0, 0, 0, 0};
    check_flags();
    put(1, 5);
    check_flags();
    final_report();
  end
endmodule
bind diag_alarm_warning_flags diag_flags_chk u_diag_flags_chk (.clk(clk), .reset(reset),
  .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe), .od_o(od_o), .rx_los_int(rx_los_int),
  .tx_fault_int(tx_fault_int), .int_req(int_req), .rx_los_oe(rx_los_oe),
  .tx_fault_oe(tx_fault_oe), .rate_sel_oe(rate_sel_oe), .int_n_oe(int_n_oe),
  .warm_pulse(warm_pulse));
